/* File: inc/dqm_pkg.sv */
// Purpose: shared constants, types and helpers for the dq map readout block
// Assumes: 100 MHz core clock, one map table shared by all channels
// Notes: map table holds one 4-bit physical index per logical dq
package dqm_pkg;
    localparam int DQM_NDQ = 10;
    localparam int DQM_NCH = 4;

    // register byte offsets on the axi4-lite port
    localparam logic [7:0] DQM_OFF_MAP_LO = 8'h00;
    localparam logic [7:0] DQM_OFF_MAP_HI = 8'h04;
    localparam logic [7:0] DQM_OFF_STAT = 8'h08;

    // status fields
    localparam int DQM_ST_SEL_LSB = 0;
    localparam int DQM_ST_MODE = 4;
    localparam int DQM_ST_RCK = 5;
    localparam int DQM_ST_ILL = 6;

    // mode register command decode
    localparam logic [4:0] DQM_MR_MAP = 5'h1d;
    localparam int DQM_OP_EN = 4;

    // reset values; the map default is arbitrary (identity)
    localparam logic [39:0] DQM_MAP_RST = 40'h9876543210;
    localparam logic [3:0] DQM_SEL_RST = 4'h0;

    // timing: longest delays in ns, rounded down to cycles, at least one
    localparam int DQM_CLK_MHZ = 100;
    localparam int DQM_T_ON_NS = 20;
    localparam int DQM_T_OFF_NS = 20;
    localparam int DQM_ON_CYC = (DQM_T_ON_NS * DQM_CLK_MHZ / 1000 < 1) ? 1 : DQM_T_ON_NS * DQM_CLK_MHZ / 1000;
    localparam int DQM_OFF_CYC = (DQM_T_OFF_NS * DQM_CLK_MHZ / 1000 < 1) ? 1 : DQM_T_OFF_NS * DQM_CLK_MHZ / 1000;

    localparam logic [1:0] DQM_RESP_OKAY = 2'b00;
    localparam logic [1:0] DQM_RESP_SLVERR = 2'b10;

    typedef enum logic {DQM_NORMAL, DQM_MAPPING} dqm_mode_t;

    // physical index for a logical select; codes above 9 select no pin
    function automatic logic [3:0] dqm_phys(input logic [39:0] map, input logic [3:0] lsel);
        if (lsel > 4'h9) begin
            return 4'hf;
        end
        return map[{lsel, 2'b00} +: 4];
    endfunction : dqm_phys
endpackage : dqm_pkg

/* File: inc/dqm_pat_if.sv */
// Purpose: carries map mode state from the control core to the pin pattern stage
// Assumes: both ends on the same clock
// Notes: lvl high means pin drives high (+1 in pam3)
`timescale 1ns/100ps
interface dqm_pat_if;
    import dqm_pkg::*;
    dqm_mode_t mode;
    logic [3:0] sel;
    logic [39:0] map;
    logic [9:0] lvl;
    logic oe;
    logic dqe;
    modport ctl (output mode, output sel, output map, input lvl, input oe, input dqe);
    modport pat (input mode, input sel, input map, output lvl, output oe, output dqe);
endinterface : dqm_pat_if

/* File: rtl/dqm_pattern.sv */
// Purpose: builds the static dq pattern for one channel from mode, select and map
// Assumes: mode/sel/map come from flops on the same clock
// Notes: one register stage; outside map mode the pins are released
`timescale 1ns/100ps
module dqm_pattern
    import dqm_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    dqm_pat_if.pat pi
);
    typedef struct packed {
        logic [9:0] lvl;
        logic oe;
        logic dqe;
    } dqm_pat_st_t;

    dqm_pat_st_t s_r;
    dqm_pat_st_t s_nxt;
    logic [3:0] phys;

    always_comb begin
        s_nxt = s_r;
        phys = dqm_phys(pi.map, pi.sel);
        if (pi.mode == DQM_MAPPING) begin
            for (int p = 0; p < DQM_NDQ; p++) begin
                s_nxt.lvl[p] = (phys != 4'(p));
            end
            s_nxt.oe = 1'b1;
            s_nxt.dqe = 1'b1;
        end else begin
            // default state: released, level parked high
            s_nxt.lvl = '1;
            s_nxt.oe = 1'b0;
            s_nxt.dqe = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '{lvl: '1, oe: 1'b0, dqe: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pi.lvl = s_r.lvl;
    assign pi.oe = s_r.oe;
    assign pi.dqe = s_r.dqe;

    a_one_pin_low: assert property (@(posedge clk) disable iff (rst)
        (pi.mode == DQM_MAPPING) && (pi.sel < 4'ha) |=>
        s_r.oe && ($countones(~s_r.lvl) == 1) && !s_r.lvl[dqm_phys($past(pi.map), $past(pi.sel))])
        else $error("selected pin not the only low pin");
    a_dqe_never_low: assert property (@(posedge clk) disable iff (rst)
        s_r.oe |-> s_r.dqe)
        else $error("error pin low during map mode");
    a_pins_release: assert property (@(posedge clk) disable iff (rst)
        (pi.mode == DQM_NORMAL) |=> !s_r.oe && !s_r.dqe && (s_r.lvl == 10'h3ff))
        else $error("pins still driven outside map mode");
endmodule : dqm_pattern

/* File: rtl/dqm_top.sv */
// Purpose: dq map readout logic with axi4-lite access to the map table and status
// Assumes: cmd_* come from the command decoder on clk; cmd_valid marks the last ck4 cycle
// Notes: one map table drives every channel; codes 10..15 give all pins high
//
// The implementer's own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps
module dqm_top
    import dqm_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire logic cmd_mrs,
    input wire logic [4:0] cmd_ma,
    input wire logic [11:0] cmd_op,
    input wire logic rck_req,
    output logic rck_en,
    output logic [39:0] dq_o,
    output logic [39:0] dq_oe,
    output logic [3:0] dqe_o,
    output logic [3:0] dqe_oe,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam int A_ON = DQM_ON_CYC;
    localparam int A_OFF = DQM_OFF_CYC;

    typedef struct packed {
        dqm_mode_t mode;
        logic [3:0] sel;
        logic rck;
        logic ill;
        logic [39:0] map;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } dqm_top_st_t;

    dqm_top_st_t s_r;
    dqm_top_st_t s_nxt;
    logic mrs_take;
    logic ill_set;
    logic ill_clr;

    dqm_pat_if pif ();

    dqm_pattern u_pattern (
        .clk(clk),
        .rst(rst),
        .pi(pif)
    );

    assign pif.mode = s_r.mode;
    assign pif.sel = s_r.sel;
    assign pif.map = s_r.map;

    // byte-lane merge used by both map registers
    function automatic logic [31:0] dqm_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return res;
    endfunction : dqm_merge

    always_comb begin
        logic [31:0] tmp;
        tmp = '0;
        s_nxt = s_r;
        // command taken on its last ck4 cycle only
        mrs_take = cmd_valid && cmd_mrs && (cmd_ma == DQM_MR_MAP);
        // anything else during map mode is a host fault, ignored but flagged
        ill_set = cmd_valid && !mrs_take && (s_r.mode == DQM_MAPPING);
        ill_clr = 1'b0;

        if (mrs_take) begin
            s_nxt.mode = cmd_op[DQM_OP_EN] ? DQM_MAPPING : DQM_NORMAL;
            s_nxt.sel = cmd_op[3:0];
        end
        // read clock follows its request only outside map mode
        if ((s_r.mode == DQM_NORMAL) && !(mrs_take && cmd_op[DQM_OP_EN])) begin
            s_nxt.rck = rck_req;
        end

        // write path: address and data in either order
        if (s_axi_awvalid && s_r.awready) begin
            s_nxt.aw_got = 1'b1;
            s_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_r.wready) begin
            s_nxt.w_got = 1'b1;
            s_nxt.wdata = s_axi_wdata;
            s_nxt.wstrb = s_axi_wstrb;
        end
        if (s_r.aw_got && s_r.w_got) begin
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = DQM_RESP_OKAY;
            case (s_r.awaddr & 8'hfc)
                DQM_OFF_MAP_LO: begin
                    s_nxt.map[31:0] = dqm_merge(s_r.map[31:0], s_r.wdata, s_r.wstrb);
                end
                DQM_OFF_MAP_HI: begin
                    tmp = dqm_merge({24'h000000, s_r.map[39:32]}, s_r.wdata, s_r.wstrb);
                    s_nxt.map[39:32] = tmp[7:0];
                end
                DQM_OFF_STAT: begin
                    ill_clr = s_r.wstrb[0] && s_r.wdata[DQM_ST_ILL];
                end
                default: begin
                    s_nxt.bresp = DQM_RESP_SLVERR;
                end
            endcase
        end else if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
        end
        // write one to clear; a new fault in the same cycle wins
        if (ill_clr) begin
            s_nxt.ill = 1'b0;
        end
        if (ill_set) begin
            s_nxt.ill = 1'b1;
        end
        s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
        s_nxt.wready = !s_nxt.w_got && !s_nxt.bvalid;

        // read path
        if (s_axi_arvalid && s_r.arready) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp = DQM_RESP_OKAY;
            s_nxt.rdata = '0;
            case (s_axi_araddr & 8'hfc)
                DQM_OFF_MAP_LO: begin
                    s_nxt.rdata = s_r.map[31:0];
                end
                DQM_OFF_MAP_HI: begin
                    s_nxt.rdata = {24'h000000, s_r.map[39:32]};
                end
                DQM_OFF_STAT: begin
                    s_nxt.rdata[DQM_ST_SEL_LSB +: 4] = s_r.sel;
                    s_nxt.rdata[DQM_ST_MODE] = (s_r.mode == DQM_MAPPING);
                    s_nxt.rdata[DQM_ST_RCK] = s_r.rck;
                    s_nxt.rdata[DQM_ST_ILL] = s_r.ill;
                end
                default: begin
                    s_nxt.rresp = DQM_RESP_SLVERR;
                end
            endcase
        end else if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
        end
        s_nxt.arready = !s_nxt.rvalid;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '0;
            s_r.mode <= DQM_NORMAL;
            s_r.sel <= DQM_SEL_RST;
            s_r.map <= DQM_MAP_RST;
            s_r.awready <= 1'b1;
            s_r.wready <= 1'b1;
            s_r.arready <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // one pattern, copied to every channel
    assign dq_o = {DQM_NCH{pif.lvl}};
    assign dq_oe = {DQM_NCH * DQM_NDQ{pif.oe}};
    assign dqe_o = {DQM_NCH{1'b1}};
    assign dqe_oe = {DQM_NCH{pif.dqe}};
    assign rck_en = s_r.rck;
    assign s_axi_awready = s_r.awready;
    assign s_axi_wready = s_r.wready;
    assign s_axi_bvalid = s_r.bvalid;
    assign s_axi_bresp = s_r.bresp;
    assign s_axi_arready = s_r.arready;
    assign s_axi_rvalid = s_r.rvalid;
    assign s_axi_rdata = s_r.rdata;
    assign s_axi_rresp = s_r.rresp;

    a_enter_on_cmd: assert property (@(posedge clk) disable iff (rst)
        mrs_take |=> (s_r.mode == DQM_MAPPING) == $past(cmd_op[DQM_OP_EN]))
        else $error("map mode does not follow enable bit");
    a_on_delay: assert property (@(posedge clk) disable iff (rst)
        mrs_take && cmd_op[DQM_OP_EN] && (cmd_op[3:0] < 4'ha) |->
        ##[1:A_ON] ($countones(~dq_o[9:0]) == 1) && dq_oe[0])
        else $error("selected pin late after enable");
    a_off_delay: assert property (@(posedge clk) disable iff (rst)
        mrs_take && !cmd_op[DQM_OP_EN] |-> ##[1:A_OFF] (dq_oe == 40'h0))
        else $error("pins not released after disable");
    a_pattern_hold: assert property (@(posedge clk) disable iff (rst)
        !mrs_take |=> $stable(s_r.mode) && $stable(s_r.sel))
        else $error("map state changed without command");
    a_rck_frozen: assert property (@(posedge clk) disable iff (rst)
        (s_r.mode == DQM_MAPPING) |=> $stable(rck_en))
        else $error("read clock changed in map mode");
    a_chan_equal: assert property (@(posedge clk) disable iff (rst)
        (dq_o[19:10] == dq_o[9:0]) && (dq_o[29:20] == dq_o[9:0]) && (dq_o[39:30] == dq_o[9:0]))
        else $error("channels differ");
    a_dqe_high: assert property (@(posedge clk) disable iff (rst)
        dq_oe[0] |-> (dqe_oe == 4'hf) && (dqe_o == 4'hf))
        else $error("error pin not high in map mode");
    a_ill_sticky: assert property (@(posedge clk) disable iff (rst)
        ill_set |=> s_r.ill)
        else $error("illegal command not flagged");
endmodule : dqm_top

/* File: testbench/dqm_host_model.sv */
// Purpose: host controller model issuing mode register commands to the map block
// Assumes: each command is reported once, in its last ck4 cycle
// Notes: idle lines carry the inverse of the last command so stale values never match
`timescale 1ns/100ps
module dqm_host_model (
    output logic cmd_valid,
    output logic cmd_mrs,
    output logic [4:0] cmd_ma,
    output logic [11:0] cmd_op,
    input wire logic clk
);
    initial begin
        cmd_valid = 1'b0;
        cmd_mrs = 1'b0;
        cmd_ma = 5'h00;
        cmd_op = 12'h000;
    end
    // only mode register commands or nops; a wrong target is issued only when the bench asks
    task automatic send(input logic mrs, input logic [4:0] ma, input logic [11:0] op);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_mrs <= mrs;
        cmd_ma <= ma;
        cmd_op <= op;
        @(posedge clk);
        cmd_valid <= 1'b0;
        cmd_mrs <= ~mrs;
        cmd_ma <= ~ma;
        cmd_op <= ~op;
    endtask : send
endmodule : dqm_host_model

/* File: testbench/dqm_top_tb_top.sv */
// Purpose: self-checking bench for the dq map readout block
// Assumes: pattern lands one edge after the edge that takes the command
// Notes: map is a random permutation from a fixed xorshift seed
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module dqm_top_tb_top;
    import dqm_pkg::*;
    logic clk, rst, rck_req, rck_en, cmd_valid, cmd_mrs;
    logic [4:0] cmd_ma;
    logic [11:0] cmd_op;
    logic [39:0] dq_o, dq_oe, map;
    logic [3:0] dqe_o, dqe_oe, wstrb;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rng, d;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [1:0] bresp, rresp, r;
    logic [3:0] p [10];
    logic [3:0] tmp;
    int failures = 0;
    int n_tests = 0;
    int cyc = 0;
    int j;

    dqm_host_model host (.cmd_valid(cmd_valid), .cmd_mrs(cmd_mrs), .cmd_ma(cmd_ma), .cmd_op(cmd_op), .clk(clk));
    dqm_top dut (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_mrs(cmd_mrs), .cmd_ma(cmd_ma),
        .cmd_op(cmd_op), .rck_req(rck_req), .rck_en(rck_en), .dq_o(dq_o), .dq_oe(dq_oe), .dqe_o(dqe_o),
        .dqe_oe(dqe_oe), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic print_verdict();
        $display("tests %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            failures++;
            print_verdict();
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction : xs

    // handshakes are judged at the falling edge, where registered outputs have settled;
    // reading them in the rising edge's own time step would race the design's flops
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
        logic aw_t;
        logic w_t;
        logic b_t;
        b_t = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b_t) begin
            @(negedge clk);
            aw_t = awvalid && (awready === 1'b1);
            w_t = wvalid && (wready === 1'b1);
            b_t = (bvalid === 1'b1);
            resp = bresp;
            @(posedge clk);
            if (aw_t) awvalid <= 1'b0;
            if (w_t) wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
        logic ar_t;
        logic r_t;
        r_t = 1'b0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!r_t) begin
            @(negedge clk);
            ar_t = arvalid && (arready === 1'b1);
            r_t = (rvalid === 1'b1);
            v = rdata;
            resp = rresp;
            @(posedge clk);
            if (ar_t) arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask : axi_rd

    // one selected pin low in every channel; codes above nine leave all high
    function automatic logic [39:0] exp_dq(input logic [39:0] m, input int s);
        logic [9:0] ch;
        ch = 10'h3ff;
        if (s < DQM_NDQ) ch[m[s*4 +: 4]] = 1'b0;
        return {DQM_NCH{ch}};
    endfunction : exp_dq

    task automatic check_pat(input int s);
        repeat (2) @(posedge clk);
        #1;
        `CHK(dq_oe, {40{1'b1}})
        `CHK(dq_o, exp_dq(map, s))
        `CHK(dqe_o, 4'hf)
        `CHK(dqe_oe, 4'hf)
        `CHK(rck_en, 1'b1)
    endtask : check_pat

    initial begin
        rst = 1'b1;
        rck_req = 1'b0;
        {awaddr, araddr, wdata, wstrb} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        rng = 32'h0b49;
        map = DQM_MAP_RST;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        `CHK(dq_oe, 40'h0)
        `CHK(dqe_oe, 4'h0)
        `CHK(dq_o, {40{1'b1}})
        `CHK(rck_en, 1'b0)
        axi_rd(DQM_OFF_STAT, d, r);
        `CHK(d[6:0], 7'h00)
        axi_rd(DQM_OFF_MAP_LO, d, r);
        `CHK(d, DQM_MAP_RST[31:0])
        axi_wr(8'h0c, 32'h5a5a5a5a, r);
        `CHK(r, DQM_RESP_SLVERR)
        axi_rd(8'h0c, d, r);
        `CHK({r, d}, {DQM_RESP_SLVERR, 32'h0})
        for (int i = 0; i < 10; i++) p[i] = 4'(i);
        for (int i = 9; i > 0; i--) begin
            rng = xs(rng);
            j = int'(rng % (i + 1));
            tmp = p[i];
            p[i] = p[j];
            p[j] = tmp;
        end
        for (int i = 0; i < 10; i++) map[i*4 +: 4] = p[i];
        axi_wr(DQM_OFF_MAP_LO, map[31:0], r);
        axi_wr(DQM_OFF_MAP_HI, {24'h0, map[39:32]}, r);
        `CHK(r, DQM_RESP_OKAY)
        axi_rd(DQM_OFF_MAP_HI, d, r);
        `CHK(d[7:0], map[39:32])
        @(posedge clk);
        rck_req <= 1'b1;
        // rck must settle on before entry: it is frozen from the enabling edge
        for (int s = 0; s < 10; s++) begin
            rng = xs(rng);
            @(posedge clk);
            if (s > 0) rck_req <= rng[0];
            host.send(1'b1, DQM_MR_MAP, 12'h010 | 12'(s));
            check_pat(s);
        end
        check_pat(9);
        host.send(1'b1, 5'h05, 12'h000);
        check_pat(9);
        axi_rd(DQM_OFF_STAT, d, r);
        `CHK(d[6:0], 7'h79)
        axi_wr(DQM_OFF_STAT, 32'h40, r);
        axi_rd(DQM_OFF_STAT, d, r);
        `CHK(d[6], 1'b0)
        host.send(1'b1, DQM_MR_MAP, 12'h01f);
        check_pat(15);
        host.send(1'b1, DQM_MR_MAP, 12'h012);
        host.send(1'b1, DQM_MR_MAP, 12'h015);
        check_pat(5);
        host.send(1'b1, DQM_MR_MAP, 12'h000);
        repeat (2) @(posedge clk);
        #1;
        `CHK(dq_oe, 40'h0)
        `CHK(dqe_oe, 4'h0)
        @(posedge clk);
        rck_req <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        `CHK(rck_en, 1'b0)
        print_verdict();
    end
endmodule : dqm_top_tb_top
